// ==== inc/pwm_gen_pkg.sv ====
package pwm_gen_pkg;
    localparam int CNT_W = 32;
    localparam int RPT_W = 8;
    localparam int MODE_W = 2;
    // mode field encodings
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    // reset values
    localparam logic [CNT_W-1:0] PERIOD_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] PHASE_RST = 32'h0000_0000;
    localparam logic [RPT_W-1:0] RPT_RST = 8'h00;
    // input clock
    localparam int REF_CLK_KHZ = 40000;
    // shortest supported continuous period, in cycles
    localparam int MIN_CONT_PERIOD = 8;

    typedef struct packed {
        logic [1:0] mode;
        logic idleLevel;
        logic firstPhaseLevel;
        logic triggerEnable;
        logic trigFalling;
        logic irqEnable;
        logic freeRun;
    } pwm_cfg_t;

    typedef struct packed {
        logic irq;
        logic dmaEvent;
    } pwm_evt_t;
endpackage

// ==== rtl/edge_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser plus selectable edge detector
module edge_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic asyncIn,
    input wire logic fallingSel,
    output logic edgeSeen
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic [1:0] warm_ff;

    // no edge until the pipe holds real pin samples, else an idle-high pin
    // looks like a rising edge just after reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            warm_ff <= 2'h0;
        end else if (warm_ff != 2'h3) begin
            warm_ff <= warm_ff + 2'h1;
        end
    end

    // first flop feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // one-cycle strobe on the chosen transition
    assign edgeSeen = (warm_ff == 2'h3)
                      && (fallingSel ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff));
endmodule // edge_sync

// ==== rtl/pwm_oneshot_continuous_gen.sv ====
`timescale 1ns/1ps
// Functional notes
// - all counting runs on the single fixed reference clock, no PLL dependence.
// - while idle the output sits at the idle level.
// - first phase drives first-phase level for first_phase_len counts of period.
// - after first phase, output is complement of first-phase level.
// - zero first-phase length gives complement for whole period.
// - first-phase length at least period plus one gives first level throughout.
// - mode 1 is one-shot, producing repeat plus one periods.
// - start strobe begins operation with latest programmed parameters.
// - one-shot end raises gated interrupt, then idles until next start.
// - mode 0 disables at once, output to idle level.
// - vsync trigger input is synchronised before edge detection.
// - rising or falling vsync edge selectable as trigger.
// - with triggering in mode 1, start only arms; counting begins on next edge.
// - later edges ignored once burst begins; rearm needs another start.
// - mode 2 runs continuously, repeat count ignored.
// - each period start copies period and phase into shadows.
// - continuous mode interrupts each period after shadow copy.
// - continuous to one-shot runs repeat plus one periods then stops.
// - interrupts gated by interrupt-enable bit.
// - dma event pulses at same moments as interrupt.
// - suspend without free-run freezes; trigger during suspend is latched.
module pwm_oneshot_continuous_gen
    import pwm_gen_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int RW = RPT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire pwm_cfg_t cfg,
    input wire logic startWr,
    input wire logic [CW-1:0] period_len,
    input wire logic [CW-1:0] first_phase_len,
    input wire logic [RW-1:0] repeat_count,
    input wire logic video_vsync_in,
    input wire logic emuSuspend,
    output logic wave_out,
    output pwm_evt_t evt,
    output logic running
);
    typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} state_t;

    state_t state_ff;
    logic [CW-1:0] perShadow_ff;
    logic [CW-1:0] phShadow_ff;
    logic [CW-1:0] cnt_ff;
    logic [RW-1:0] rptLeft_ff;
    logic trigPend_ff;
    logic wasCont_ff;
    logic edgeSeen;
    logic frozen;
    logic periodEnd;
    logic lastPeriod;
    logic [RW-1:0] rptNow;
    logic startOk;
    logic [CW:0] phWide;
    logic [CW:0] perWide;

    // synchronised, polarity-selected trigger
    edge_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn(video_vsync_in),
        .fallingSel(cfg.trigFalling),
        .edgeSeen(edgeSeen)
    );

    assign frozen = emuSuspend & ~cfg.freeRun;
    assign periodEnd = (state_ff == S_RUN) && (cnt_ff >= perShadow_ff);
    // first one-shot cycle after continuous reads the count straight from the input
    assign rptNow = (wasCont_ff && cfg.mode == MODE_ONESHOT) ? repeat_count : rptLeft_ff;
    assign lastPeriod = (rptNow == '0);
    assign startOk = startWr && (cfg.mode != MODE_OFF);
    assign phWide = {1'b0, phShadow_ff};
    assign perWide = {1'b0, perShadow_ff} + {{CW{1'b0}}, 1'b1};

    // event capture stays alive in suspend; armed edge is held until consumed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trigPend_ff <= 1'b0;
        end else if (cfg.mode == MODE_OFF || startOk) begin
            trigPend_ff <= 1'b0;
        end else if (state_ff == S_ARMED && edgeSeen) begin
            trigPend_ff <= 1'b1;
        end else if (!frozen) begin
            trigPend_ff <= 1'b0;
        end
    end

    // sequencing; mode 0 wins over everything
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
        end else if (cfg.mode == MODE_OFF) begin
            state_ff <= S_IDLE;
        end else if (startOk) begin
            if (cfg.mode == MODE_ONESHOT && cfg.triggerEnable) begin
                state_ff <= S_ARMED;
            end else begin
                state_ff <= S_RUN;
            end
        end else if (!frozen) begin
            case (state_ff)
                S_ARMED: begin
                    if (edgeSeen || trigPend_ff) begin
                        state_ff <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (periodEnd && cfg.mode == MODE_ONESHOT && lastPeriod) begin
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= state_ff;
                end
            endcase
        end
    end

    // period counter and shadow capture at each period start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            perShadow_ff <= PERIOD_RST;
            phShadow_ff <= PHASE_RST;
        end else if (startOk || (!frozen && state_ff == S_ARMED)
                     || (!frozen && periodEnd)) begin
            cnt_ff <= '0;
            perShadow_ff <= period_len;
            phShadow_ff <= first_phase_len;
        end else if (!frozen && state_ff == S_RUN) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // repeat counter; reloaded on entering one-shot from continuous
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rptLeft_ff <= RPT_RST;
            wasCont_ff <= 1'b0;
        end else if (startOk || state_ff != S_RUN) begin
            rptLeft_ff <= repeat_count;
            wasCont_ff <= (cfg.mode == MODE_CONT);
        end else if (!frozen) begin
            wasCont_ff <= (cfg.mode == MODE_CONT);
            if (periodEnd && cfg.mode == MODE_ONESHOT && !lastPeriod) begin
                rptLeft_ff <= rptNow - 1'b1;
            end else if (wasCont_ff && cfg.mode == MODE_ONESHOT) begin
                rptLeft_ff <= repeat_count;
            end
        end
    end

    // output pin; frozen holds the last level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wave_out <= 1'b0;
        end else if (cfg.mode == MODE_OFF || state_ff != S_RUN) begin
            wave_out <= cfg.idleLevel;
        end else if (!frozen) begin
            // count compare against shadow phase covers both 0% and 100%
            if ({1'b0, cnt_ff} < phWide && {1'b0, cnt_ff} < perWide) begin
                wave_out <= cfg.firstPhaseLevel;
            end else begin
                wave_out <= ~cfg.firstPhaseLevel;
            end
        end
    end

    // single-cycle interrupt and dma strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evt <= '0;
        end else begin
            evt.irq <= 1'b0;
            evt.dmaEvent <= 1'b0;
            if (!frozen && cfg.irqEnable && periodEnd && cfg.mode != MODE_OFF) begin
                if (cfg.mode == MODE_CONT || lastPeriod) begin
                    evt.irq <= 1'b1;
                    evt.dmaEvent <= 1'b1;
                end
            end
            // the copy made by a continuous start is flagged too
            if (!frozen && cfg.irqEnable && startOk && cfg.mode == MODE_CONT) begin
                evt.irq <= 1'b1;
                evt.dmaEvent <= 1'b1;
            end
        end
    end

    // status flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
        end else begin
            running <= (state_ff == S_RUN);
        end
    end

    property p_disable_idle;
        @(posedge ref_clk) disable iff (rst)
        (cfg.mode == MODE_OFF) |=> (wave_out == $past(cfg.idleLevel));
    endproperty
    a_disable_idle: assert property (p_disable_idle) else $error("disable not idle");

    property p_idle_level;
        @(posedge ref_clk) disable iff (rst)
        (state_ff == S_IDLE) |=> (wave_out == $past(cfg.idleLevel));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

    property p_irq_one_cycle;
        @(posedge ref_clk) disable iff (rst)
        evt.irq |=> !evt.irq;
    endproperty
    a_irq_one_cycle: assert property (p_irq_one_cycle) else $error("irq too long");

    property p_dma_with_irq;
        @(posedge ref_clk) disable iff (rst)
        evt.irq == evt.dmaEvent;
    endproperty
    a_dma_with_irq: assert property (p_dma_with_irq) else $error("dma not aligned");

    property p_irq_gated;
        @(posedge ref_clk) disable iff (rst)
        evt.irq |-> $past(cfg.irqEnable);
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq ungated");

    property p_start_off;
        @(posedge ref_clk) disable iff (rst)
        (startWr && cfg.mode == MODE_OFF) |=> (state_ff == S_IDLE);
    endproperty
    a_start_off: assert property (p_start_off) else $error("start in mode 0");

    sequence s_armStart;
        startOk && cfg.mode == MODE_ONESHOT && cfg.triggerEnable;
    endsequence
    property p_arm_only;
        @(posedge ref_clk) disable iff (rst)
        s_armStart |=> (state_ff == S_ARMED);
    endproperty
    a_arm_only: assert property (p_arm_only) else $error("start did not arm");

    property p_shadow_copy;
        @(posedge ref_clk) disable iff (rst)
        (periodEnd && !frozen && !startOk) |=> (perShadow_ff == $past(period_len));
    endproperty
    a_shadow_copy: assert property (p_shadow_copy) else $error("shadow not copied");

    property p_freeze;
        @(posedge ref_clk) disable iff (rst)
        (frozen && state_ff == S_RUN && cfg.mode != MODE_OFF && !startOk)
            |=> $stable(wave_out) && $stable(cnt_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("suspend not frozen");
endmodule // pwm_oneshot_continuous_gen

// ==== tb/pwm_load_model.sv ====
`timescale 1ns/1ps
// load on the pin: a driver or filter only sees the averaged level
module pwm_load_model
    import pwm_gen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic wave_out,
    input wire pwm_evt_t evt,
    output logic [15:0] highCnt,
    output logic [15:0] riseCnt,
    output logic [15:0] irqCnt,
    output logic [15:0] dmaCnt
);
    logic prevLvl;

    // integrate high time, pulses and events until cleared
    always_ff @(posedge ref_clk) begin
        prevLvl <= wave_out;
        if (clr) begin
            highCnt <= 16'h0;
            riseCnt <= 16'h0;
            irqCnt <= 16'h0;
            dmaCnt <= 16'h0;
        end else begin
            highCnt <= highCnt + 16'(wave_out);
            riseCnt <= riseCnt + 16'(wave_out & ~prevLvl);
            irqCnt <= irqCnt + 16'(evt.irq);
            dmaCnt <= dmaCnt + 16'(evt.dmaEvent);
        end
    end
endmodule // pwm_load_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
 $display("[ERR] %s expected %0h seen %0h", nm, e, g); errorCnt++; end end
module testbench;
    import pwm_gen_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pwm_cfg_t cfg = '0;
    logic startWr = 1'b0;
    logic [CNT_W-1:0] period_len = 32'h9;
    logic [CNT_W-1:0] first_phase_len = 32'h3;
    logic [RPT_W-1:0] repeat_count = 8'h0;
    logic video_vsync_in = 1'b0;
    logic emuSuspend = 1'b0;
    logic clr = 1'b1;
    logic wave_out, running, lvl;
    pwm_evt_t evt;
    logic [15:0] highCnt, riseCnt, irqCnt, dmaCnt;
    int errorCnt = 0;
    int compares = 0;

    pwm_oneshot_continuous_gen pwm_oneshot_continuous_gen_i (.ref_clk(ref_clk), .rst(rst),
        .cfg(cfg), .startWr(startWr), .period_len(period_len),
        .first_phase_len(first_phase_len), .repeat_count(repeat_count),
        .video_vsync_in(video_vsync_in), .emuSuspend(emuSuspend), .wave_out(wave_out),
        .evt(evt), .running(running));
    pwm_load_model pwm_load_model_i (.ref_clk(ref_clk), .clr(clr), .wave_out(wave_out),
        .evt(evt), .highCnt(highCnt), .riseCnt(riseCnt), .irqCnt(irqCnt), .dmaCnt(dmaCnt));

    // 40 MHz reference
    always #12.5 ref_clk = ~ref_clk;

    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // parameters settle a cycle ahead of the start strobe
    task automatic start(input logic [1:0] m, input logic [31:0] p, h, input logic [7:0] r);
        cfg.mode = m;
        period_len = p;
        first_phase_len = h;
        repeat_count = r;
        cyc(1);
        startWr = 1'b1;
        clr = 1'b1;
        cyc(1);
        startWr = 1'b0;
        clr = 1'b0;
    endtask

    task automatic wait_run(input logic want);
        int n;
        n = 0;
        while (running !== want && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic burst(input logic [31:0] p, h, input logic [7:0] r,
                         input logic [15:0] eh, er, ei);
        start(MODE_ONESHOT, p, h, r);
        wait_run(1'b1);
        wait_run(1'b0);
        cyc(3);
        `CHK("high", eh, highCnt)
        `CHK("pulses", er, riseCnt)
        `CHK("irq", ei, irqCnt)
        `CHK("dma", ei, dmaCnt)
        `CHK("idle", cfg.idleLevel, wave_out)
    endtask

    // watchdog sized well beyond the whole sequence
    initial begin
        repeat (20000) @(negedge ref_clk);
        errorCnt++;
        complete_run();
    end

    initial begin
        cfg.idleLevel = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(2);
        `CHK("idle after reset", 1'b1, wave_out)
        cfg.idleLevel = 1'b0;
        cfg.firstPhaseLevel = 1'b1;
        cfg.irqEnable = 1'b1;
        burst(32'h9, 32'h3, 8'h2, 16'h9, 16'h3, 16'h1);
        burst(32'h9, 32'h0, 8'h1, 16'h0, 16'h0, 16'h1);
        burst(32'h9, 32'ha, 8'h0, 16'ha, 16'h1, 16'h1);
        burst(32'h9, 32'hc, 8'h1, 16'h14, 16'h1, 16'h1);
        cfg.firstPhaseLevel = 1'b0;
        burst(32'h9, 32'h3, 8'h0, 16'h7, 16'h1, 16'h1);
        cfg.firstPhaseLevel = 1'b1;
        cfg.irqEnable = 1'b0;
        burst(32'h7, 32'h2, 8'h3, 16'h8, 16'h4, 16'h0);
        cfg.irqEnable = 1'b1;
        start(MODE_OFF, 32'h9, 32'h3, 8'h0);
        cyc(20);
        `CHK("off start", 16'h0, highCnt)
        // rising then falling trigger, extra selected edge inside the burst, only the opposite edge after it
        cfg.triggerEnable = 1'b1;
        for (int i = 0; i < 2; i++) begin
            cfg.trigFalling = i[0];
            video_vsync_in = i[0];
            cyc(4);
            start(MODE_ONESHOT, 32'h9, 32'h3, 8'h1);
            cyc(20);
            `CHK("armed only", 1'b0, running)
            video_vsync_in = ~i[0];
            cyc(8);
            `CHK("triggered", 1'b1, running)
            video_vsync_in = i[0];
            cyc(3);
            video_vsync_in = ~i[0];
            wait_run(1'b0);
            cyc(3);
            `CHK("one burst", 16'h6, highCnt)
            video_vsync_in = i[0];
            cyc(10);
            `CHK("no rearm", 1'b0, running)
        end
        cfg.triggerEnable = 1'b0;
        start(MODE_CONT, 32'h9, 32'h4, 8'h0);
        cyc(20);
        `CHK("cont first irq", 16'h2, irqCnt)
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(40);
        `CHK("cont irq", 16'h4, irqCnt)
        `CHK("cont high", 16'h10, highCnt)
        `CHK("cont running", 1'b1, running)
        first_phase_len = 32'h6;
        cyc(20);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(40);
        `CHK("shadow high", 16'h18, highCnt)
        // frozen output, no events while suspended
        emuSuspend = 1'b1;
        cyc(2);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        lvl = wave_out;
        cyc(20);
        `CHK("frozen high", lvl ? 16'h14 : 16'h0, highCnt)
        `CHK("frozen irq", 16'h0, irqCnt)
        emuSuspend = 1'b0;
        cyc(5);
        cfg.mode = MODE_ONESHOT;
        repeat_count = 8'h1;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        wait_run(1'b0);
        cyc(3);
        `CHK("graceful stop", 1'b0, running)
        `CHK("graceful irq", 16'h1, irqCnt)
        cfg.idleLevel = 1'b1;
        start(MODE_CONT, 32'h9, 32'h1, 8'h0);
        cyc(15);
        cfg.mode = MODE_OFF;
        cyc(2);
        `CHK("disable level", 1'b1, wave_out)
        complete_run();
    end
endmodule // testbench
